// File: logic/srt_consts.svh
`ifndef SRT_CONSTS_SVH
`define SRT_CONSTS_SVH
// Byte address of the timing control register.
`define SRT_ADDR_TIMING 8'h00
// Byte address of the sticky event status register.
`define SRT_ADDR_STATUS 8'h04
// Byte address of the interrupt mask register.
`define SRT_ADDR_MASK 8'h08
// Field positions inside the timing control register.
`define SRT_TRC_LSB 8
`define SRT_TRC_MSB 10
`define SRT_CMD_DLY_BIT 11
`define SRT_PAR_EN_BIT 12
// Reset value of the timing control register.
`define SRT_TIMING_RST 32'h0000_0000
// Row cycle code 001 gives this many cycles plus one; each step adds one.
`define SRT_TRC_BASE 4'h3
// Status bits: parity error and reserved row cycle code seen.
`define SRT_ST_PERR 0
`define SRT_ST_RSVD 1
`endif

// File: logic/srt_pkg.sv
`default_nettype none
package srt_pkg;
	// Sequencer states of the row activate path.
	typedef enum logic [1:0] {
		SRT_IDLE,
		SRT_ADDR,
		SRT_WAIT
	} srt_state_t;
endpackage
`default_nettype wire

// File: logic/srt_lane_par.sv
`timescale 1ns/10ps
`default_nettype none
// Even parity for one byte lane, registered, with a mismatch flag.
module srt_lane_par (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] byte_in,
	input wire logic par_in,
	input wire logic check_in,
	output logic par_out,
	output logic err_out
);
	logic par_next;
	logic err_next;

	// Parity of the byte, and a mismatch only while a check is requested.
	always_comb begin
		par_next = ^byte_in;
		err_next = check_in & (par_next != par_in);
	end

	// Registering both keeps the pin and flag glitch free.
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			par_out <= 1'b0;
			err_out <= 1'b0;
		end else begin
			par_out <= par_next;
			err_out <= err_next;
		end
	end
endmodule // srt_lane_par
`default_nettype wire

// File: logic/srt_timing_ctrl.sv
// Behaviour
// - Keep at least row_cycle_time cycles between activates; codes 1..7 mean 4..10, reset 0.
// - Command drive delay set adds one cycle to the row cycle time.
// - Command delay bit: chip select same cycle as address, or one later.
// - Parity disabled by reset: parity pins released, no read check.
// - Parity enabled: drive parity pins on writes, check them on reads.
// - All counts run on the single controller clock.
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "srt_consts.svh"
module srt_timing_ctrl
	import srt_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	// Classic Wishbone slave.
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	output logic irq_out,
	// Sequencer side: activate request and write/read data paths.
	input wire logic act_req_in,
	output logic act_ack_out,
	output logic cmd_valid_out,
	output logic cs_n_out,
	input wire logic wr_in,
	input wire logic rd_valid_in,
	input wire logic [31:0] data_in,
	// Parity pins as input, output and enable.
	input wire logic [3:0] parity_in,
	output logic [3:0] parity_out,
	output logic [3:0] parity_oe_out
);
	logic [31:0] timing_reg, timing_next;
	logic [1:0] status_reg, status_next;
	logic [1:0] mask_reg, mask_next;
	logic [31:0] rdat_reg, rdat_next;
	logic ack_reg, ack_next;
	logic irq_reg, irq_next;
	srt_state_t state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic act_ack_reg, act_ack_next;
	logic cmdv_reg, cmdv_next;
	logic cs_n_reg, cs_n_next;
	logic [3:0] oe_reg, oe_next;
	logic [3:0] par_gen;
	logic [3:0] par_err;
	logic [2:0] trc_code;
	logic cmd_dly;
	logic par_en;
	logic [3:0] trc_cycles;
	logic bus_req;
	logic perr_evt;
	logic rsvd_evt;

	assign trc_code = timing_reg[`SRT_TRC_MSB:`SRT_TRC_LSB];
	assign cmd_dly = timing_reg[`SRT_CMD_DLY_BIT];
	assign par_en = timing_reg[`SRT_PAR_EN_BIT];
	assign bus_req = wb_cyc_in & wb_stb_in & ~ack_reg;
	// Row cycle length plus the command delay stretch.
	assign trc_cycles = 4'(trc_code) + `SRT_TRC_BASE + 4'(cmd_dly);

	// One lane checker per byte, parity drawn per lane.
	// Lanes see zeros while parity is off, so the registered parity pins stay low then.
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			srt_lane_par u_lane (
				.sys_clk_in(sys_clk_in),
				.sys_rst_in(sys_rst_in),
				.byte_in(data_in[8*g+7:8*g] & {8{par_en}}),
				.par_in(parity_in[g]),
				.check_in(par_en & rd_valid_in),
				.par_out(par_gen[g]),
				.err_out(par_err[g])
			);
		end
	endgenerate

	assign perr_evt = |par_err;
	assign rsvd_evt = act_req_in & (trc_code == 3'h0);

	// Register file next values; a hardware set beats a write-one clear.
	always_comb begin
		timing_next = timing_reg;
		mask_next = mask_reg;
		status_next = status_reg;
		rdat_next = rdat_reg;
		ack_next = bus_req;
		if (bus_req && wb_we_in) begin
			if (wb_adr_in == `SRT_ADDR_TIMING) begin
				for (int i = 0; i < 4; i++) begin
					if (wb_sel_in[i]) begin
						timing_next[8*i+:8] = wb_dat_in[8*i+:8];
					end
				end
				timing_next[31:13] = 19'h0;
				timing_next[7:0] = 8'h00;
			end else if (wb_adr_in == `SRT_ADDR_STATUS) begin
				if (wb_sel_in[0]) begin
					status_next = status_reg & ~wb_dat_in[1:0];
				end
			end else if (wb_adr_in == `SRT_ADDR_MASK) begin
				if (wb_sel_in[0]) begin
					mask_next = wb_dat_in[1:0];
				end
			end
		end
		if (perr_evt) begin
			status_next[`SRT_ST_PERR] = 1'b1;
		end
		if (rsvd_evt) begin
			status_next[`SRT_ST_RSVD] = 1'b1;
		end
		if (bus_req && !wb_we_in) begin
			if (wb_adr_in == `SRT_ADDR_TIMING) begin
				rdat_next = timing_reg;
			end else if (wb_adr_in == `SRT_ADDR_STATUS) begin
				rdat_next = {30'h0, status_reg};
			end else if (wb_adr_in == `SRT_ADDR_MASK) begin
				rdat_next = {30'h0, mask_reg};
			end else begin
				rdat_next = 32'h0; // Unmapped reads answer zero.
			end
		end
		irq_next = |(status_next & mask_next);
	end

	// Register file storage.
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			timing_reg <= `SRT_TIMING_RST;
			status_reg <= 2'h0;
			mask_reg <= 2'h0;
			rdat_reg <= 32'h0;
			ack_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			timing_reg <= timing_next;
			status_reg <= status_next;
			mask_reg <= mask_next;
			rdat_reg <= rdat_next;
			ack_reg <= ack_next;
			irq_reg <= irq_next;
		end
	end

	// Activate sequencer: address valid, optional chip select delay, then wait.
	// A reserved code is refused, since no legal spacing exists for it.
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		act_ack_next = 1'b0;
		cmdv_next = 1'b0;
		cs_n_next = 1'b1;
		case (state_reg)
			SRT_IDLE: begin
				if (act_req_in && trc_code != 3'h0) begin
					cmdv_next = 1'b1;
					cnt_next = trc_cycles - 4'h1;
					if (cmd_dly) begin
						state_next = SRT_ADDR;
					end else begin
						cs_n_next = 1'b0;
						act_ack_next = 1'b1;
						state_next = SRT_WAIT;
					end
				end
			end
			SRT_ADDR: begin
				cmdv_next = 1'b1;
				cs_n_next = 1'b0;
				act_ack_next = 1'b1;
				cnt_next = cnt_reg - 4'h1;
				state_next = SRT_WAIT;
			end
			SRT_WAIT: begin
				if (cnt_reg <= 4'h1) begin
					state_next = SRT_IDLE;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			default: begin
				state_next = SRT_IDLE;
			end
		endcase
	end

	// Sequencer registers.
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			state_reg <= SRT_IDLE;
			cnt_reg <= 4'h0;
			act_ack_reg <= 1'b0;
			cmdv_reg <= 1'b0;
			cs_n_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			act_ack_reg <= act_ack_next;
			cmdv_reg <= cmdv_next;
			cs_n_reg <= cs_n_next;
		end
	end

	// Parity pins driven only on enabled writes, aligned with lane parity.
	always_comb begin
		oe_next = {4{par_en & wr_in}};
	end

	// Output enable register, one cycle after the write level like the lane parity.
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			oe_reg <= 4'h0;
		end else begin
			oe_reg <= oe_next;
		end
	end

	assign wb_dat_out = rdat_reg;
	assign wb_ack_out = ack_reg;
	assign irq_out = irq_reg;
	assign act_ack_out = act_ack_reg;
	assign cmd_valid_out = cmdv_reg;
	assign cs_n_out = cs_n_reg;
	assign parity_out = par_gen;
	assign parity_oe_out = oe_reg;
endmodule // srt_timing_ctrl
`default_nettype wire

// File: bench/srt_timing_ctrl_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module srt_timing_ctrl_monitor (
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic wb_ack_out,
	input wire logic act_ack_out,
	input wire logic cmd_valid_out,
	input wire logic cs_n_out,
	input wire logic wr_in,
	input wire logic [3:0] parity_oe_out
);
	logic [4:0] fld_reg;
	logic [3:0] gap_reg;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);
	// Copy of bits 12:8, taken on the edge that accepts a write.
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) fld_reg <= 5'h00;
		else if (wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_adr_in == 8'h00
			&& wb_sel_in[1]) fld_reg <= wb_dat_in[12:8];
	end
	// Cycles since the last activate; it saturates so a long idle never wraps.
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) gap_reg <= 4'hf;
		else if (act_ack_out) gap_reg <= 4'h1;
		else if (gap_reg != 4'hf) gap_reg <= gap_reg + 4'h1;
	end
	property p_ack; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
	property p_trc; act_ack_out |-> gap_reg >= fld_reg[2:0] + fld_reg[3] + 4'h3; endproperty
	a_trc: assert property (p_trc) else $error("row cycle short");
	property p_rsvd; fld_reg[2:0] == 3'h0 |-> !act_ack_out; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved code ran");
	property p_dly; act_ack_out |-> !cs_n_out && cmd_valid_out
		&& $past(cmd_valid_out) == fld_reg[3]; endproperty
	a_dly: assert property (p_dly) else $error("select timing");
	property p_cs; !cs_n_out |-> act_ack_out; endproperty
	a_cs: assert property (p_cs) else $error("stray select");
	property p_par_off; !fld_reg[4] && !$past(fld_reg[4]) |-> parity_oe_out == 4'h0; endproperty
	a_par_off: assert property (p_par_off) else $error("parity driven");
	property p_par_on; fld_reg[4] && wr_in |=> parity_oe_out == 4'hf; endproperty
	a_par_on: assert property (p_par_on) else $error("parity not driven");
	c_dly: cover property (act_ack_out && fld_reg[3]);
	c_par: cover property (parity_oe_out == 4'hf);
	c_wr: cover property (wb_ack_out && wb_we_in);
endmodule // srt_timing_ctrl_monitor
bind srt_timing_ctrl srt_timing_ctrl_monitor mon (.*);
`default_nettype wire

// File: bench/srt_sdram_model.sv
`timescale 1ns/10ps
`default_nettype none
module srt_sdram_model (
	input wire logic sys_clk_in,
	input wire logic rd_in,
	input wire logic [3:0] flip_in,
	input wire logic [31:0] data_in,
	input wire logic [3:0] oe_in,
	input wire logic [3:0] drv_in,
	output logic [3:0] pin_out
);
	logic [3:0] last_reg = 4'h0;
	logic [3:0] rd_par;
	// Stored even parity per byte lane, corrupted where the bench asks.
	assign rd_par = {^data_in[31:24], ^data_in[23:16], ^data_in[15:8], ^data_in[7:0]} ^ flip_in;
	// Undriven pins toggle, so a stale level can never pass for data.
	assign pin_out = (oe_in & drv_in) | (~oe_in & (rd_in ? rd_par : ~last_reg));
	always @(posedge sys_clk_in) last_reg <= pin_out;
endmodule // srt_sdram_model
`default_nettype wire

// File: bench/srt_timing_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module srt_timing_ctrl_tb;
	typedef struct {logic [7:0] a; logic [3:0] s; logic [31:0] d; logic [31:0] e;} srt_row_t;
	srt_row_t rows [5] = '{'{8'h00, 4'hf, 32'hffff_ffff, 32'h1f00}, '{8'h00, 4'h1, 32'h0, 32'h1f00},
		'{8'h00, 4'h2, 32'h0, 32'h0}, '{8'h08, 4'hf, 32'hffff_ffff, 32'h3}, '{8'h0c, 4'hf, 32'h1, 32'h0}};
	logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, act = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf, flip = 4'h0, pin, pout, poe;
	logic [31:0] dat = 32'h0, dw = 32'h0, q, rdat;
	logic ack, irq, aack, cmdv, csn;
	int fails = 0, checks = 0, n;
	// Clock at 125 MHz.
	always #4 clk = ~clk;
	srt_timing_ctrl dut (.sys_clk_in(clk), .sys_rst_in(rst), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .irq_out(irq), .act_req_in(act), .act_ack_out(aack), .cmd_valid_out(cmdv),
		.cs_n_out(csn), .wr_in(wr), .rd_valid_in(rd), .data_in(dw), .parity_in(pin),
		.parity_out(pout), .parity_oe_out(poe));
	srt_sdram_model mem (.sys_clk_in(clk), .rd_in(rd), .flip_in(flip), .data_in(dw), .oe_in(poe),
		.drv_in(pout), .pin_out(pin));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// One classic cycle; read data is taken at the edge that sees ack.
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		int k;
		@(posedge clk);
		{cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
		k = 0;
		do @(posedge clk); while (ack !== 1'b1 && ++k < 20);
		if (ack !== 1'b1) fails++;
		q = rdat;
		{cyc, stb} <= 2'b00;
	endtask
	// Holds the request and counts edges between two activates.
	task automatic gap(input int e);
		act <= 1'b1;
		n = 0;
		do @(posedge clk); while (aack !== 1'b1 && ++n < 30);
		n = 0;
		do begin @(posedge clk); n++; end while (aack !== 1'b1 && n < 30);
		act <= 1'b0;
		chk(n, e);
		repeat (14) @(posedge clk);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 12; i += 4) begin
			wb(1'b0, i[7:0], 4'hf, 32'h0);
			chk(q, 32'h0);
		end
		foreach (rows[i]) begin
			wb(1'b1, rows[i].a, rows[i].s, rows[i].d);
			wb(1'b0, rows[i].a, 4'hf, 32'h0);
			chk(q, rows[i].e);
		end
		for (int k = 1; k < 15; k++) begin
			wb(1'b1, 8'h00, 4'hf, (k > 7 ? 32'h800 : 32'h0) | 32'((k - 1) % 7 + 1) << 8);
			gap((k - 1) % 7 + 4 + (k > 7));
		end
		// A reserved code leaves the request waiting and flags it.
		wb(1'b1, 8'h00, 4'hf, 32'h0);
		act <= 1'b1;
		repeat (6) @(posedge clk);
		act <= 1'b0;
		chk(irq, 1'b1);
		wb(1'b0, 8'h04, 4'hf, 32'h0);
		chk(q, 32'h2);
		wb(1'b1, 8'h08, 4'hf, 32'h0);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		wb(1'b1, 8'h04, 4'hf, 32'h2);
		wb(1'b1, 8'h08, 4'hf, 32'h3);
		wb(1'b0, 8'h04, 4'hf, 32'h0);
		chk(q | irq, 32'h0);
		// Parity enabled, then disabled: pin drive and a clean and a bad read.
		for (int p = 1; p >= 0; p--) begin
			wb(1'b1, 8'h00, 4'hf, 32'(p << 12) | 32'h100);
			{wr, dw} <= {1'b1, 32'h0103_07ff};
			@(posedge clk);
			wr <= 1'b0;
			@(posedge clk);
			chk(poe, {4{p[0]}});
			chk(pout, p ? 4'ha : 4'h0);
			for (int f = 0; f < 8; f += 4) begin
				{rd, flip} <= {1'b1, f[3:0]};
				@(posedge clk);
				rd <= 1'b0;
				wb(1'b0, 8'h04, 4'hf, 32'h0);
				chk(q, p && f);
				wb(1'b1, 8'h04, 4'hf, 32'h1);
			end
		end
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, 8'h00, 4'hf, 32'h0);
		chk(q, 32'h0);
		chk({poe, pout}, 32'h0);
		tally_and_finish;
	end
	// Cuts a hang short well after the tests should end.
	initial begin
		#200000;
		fails++;
		tally_and_finish;
	end
endmodule // srt_timing_ctrl_tb
`default_nettype wire
